/* hw/debug_regs_pkg.sv */
// Constants for the background debug status register block
package debug_regs_pkg;
    localparam logic [15:0] ADDR_BASE = 16'hff00;
    localparam logic [15:0] ADDR_LAST = 16'hff07;
    localparam logic [15:0] ADDR_STATUS = 16'hff01;
    localparam logic [15:0] ADDR_CCR = 16'hff06;
    localparam logic [15:0] ADDR_INR = 16'hff07;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_TAG = 5;
    localparam int BIT_SDV = 4;
    localparam int BIT_TRACE = 3;
    localparam int BIT_CLKSEL = 2;
    localparam int BIT_UNSECURE_FLAG = 1;
    localparam logic [7:0] CCR_SPECIAL_RESET = 8'hd8;
    localparam logic [7:0] CCR_RESET = 8'hd0;
    localparam int TAG_DELAY_CYCLES = 16;
    localparam int CLK_SWITCH_CYCLES = 150;
    localparam logic [7:0] TAG_CNT_W = 8'd16;
    localparam logic [7:0] CLK_CNT_W = 8'd150;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SPECIAL_SINGLE = 2'b01,
        MODE_SPECIAL_PERIPH = 2'b11,
        MODE_EMULATION = 2'b10
    } chip_mode_t;
endpackage

/* hw/background_debug_status_regs.sv */
// Background debug status, saved condition codes and register position shadow
//
// Function
// - Tag low half when low tag pin low
// - Registers served only to debug-map commands
// - Status at ff01, active resets per mode
// - Active set by entry, cleared by firmware
// - Enable gates activation; hardware commands unaffected
// - Firmware sets enable after reset, verify
// - Entry sets active, maps firmware table
// - Tag bit by tag-go; 16-cycle start
// - Data-valid set on data, cleared next command
// - Trace follows back-to-back single-step commands
// - Clock switch waits 150 cycles, next command
// - Clock chosen from PLL select and bit
// - Acknowledge of switching write uses new clock
// - Unsecure resets zero, secure firmware writes
// - Unsecure clears security until reset or a secure firmware write of zero
// - Saved codes capture on entry, d8 special single-chip
// - Saved codes readable, writable, restored value
// - Position register read-only, shadows base bits
// - Registers visible ff00-ff07 only while active
`timescale 1ns/100ps
module background_debug_status_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire debug_regs_pkg::chip_mode_t chip_mode,
    input wire logic debug_map_read_cmd,
    input wire logic debug_map_write_cmd,
    input wire logic hw_cmd,
    input wire logic secure_fw,
    input wire logic std_fw,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic activate_req,
    input wire logic exit_store,
    input wire logic tag_go_command,
    input wire logic fw_data_done,
    input wire logic cmd_received,
    input wire logic single_step_command,
    input wire logic [7:0] condition_code_register,
    input wire logic [3:0] block_base_bits,
    input wire logic pll_select_input,
    input wire logic external_bus_clock,
    input wire logic low_byte_tag_pin,
    input wire logic low_strobe_en,
    input wire logic iq_load,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic user_read_blocked,
    output logic debug_active_flag,
    output logic fw_table_mapped,
    output logic serial_enabled,
    output logic tagging_active,
    output logic low_tag,
    output logic use_alt_clock,
    output logic clock_switch_busy,
    output logic security_off,
    output logic [7:0] ccr_restore
);
    import debug_regs_pkg::*;

    // Status bits
    logic enable_q;
    logic active_q;
    logic tag_q;
    logic sdv_q;
    logic trace_q;
    logic clksel_q;
    logic unsecure_flag_q;
    // Saved codes and delay counters
    logic [7:0] ccr_q;
    logic [7:0] tag_cnt_q;
    logic [7:0] clk_cnt_q;
    // Tagging, serial and edge state
    logic tagging_q;
    logic serial_q;
    logic ext_clk_q;
    logic low_tag_q;
    // Registered outputs
    logic [7:0] rdata_q;
    logic rdata_valid_q;
    logic user_block_q;
    logic alt_q;
    logic busy_q;
    // Decode wires
    logic special_single;
    logic reset_active;
    logic wr_status;
    logic wr_ccr;
    logic rd_hit;
    logic enter;
    logic cmd_ok;
    logic ext_fall;
    logic wr_enable;
    logic wr_clksel;
    logic clk_change;
    logic wr_unsecure_flag;
    logic fw_exit;
    logic tag_start;
    logic tag_done;
    logic tag_counting;
    logic clk_counting;
    logic user_hit;
    logic alt_sel;
    logic low_tag_d;
    logic [7:0] status_view;
    logic [7:0] position_view;
    logic [7:0] rdata_d;

    // Mode decode: the active flag comes out of reset set in both special modes
    assign special_single = (chip_mode == MODE_SPECIAL_SINGLE);
    assign reset_active = special_single || (chip_mode == MODE_SPECIAL_PERIPH);

    // Commands are only served while the serial system is on
    assign cmd_ok = serial_q;
    assign wr_status = debug_map_write_cmd && cmd_ok && (addr == ADDR_STATUS);
    assign wr_ccr = debug_map_write_cmd && cmd_ok && (addr == ADDR_CCR);
    assign rd_hit = debug_map_read_cmd && cmd_ok &&
                    (addr >= ADDR_BASE) && (addr <= ADDR_LAST);

    // Write qualifiers per bit: who may change what
    assign wr_enable = wr_status && (hw_cmd || std_fw || secure_fw);
    assign wr_clksel = wr_status && hw_cmd;
    assign clk_change = wr_clksel && (wdata[BIT_CLKSEL] != clksel_q);
    assign wr_unsecure_flag = wr_status && secure_fw && special_single;
    assign fw_exit = exit_store && std_fw;

    // Entry is refused while the enable bit is clear
    assign enter = activate_req && enable_q && !active_q;

    // Tag-go start and the end of the start-up count
    assign tag_start = tag_go_command && cmd_ok;
    assign tag_counting = (tag_cnt_q != 8'h00);
    assign tag_done = (tag_cnt_q == 8'h01);
    assign clk_counting = (clk_cnt_q != 8'h00);

    // Low tag on a falling external clock seen through mclk sampling
    assign ext_fall = ext_clk_q && !external_bus_clock;
    assign low_tag_d = tagging_q && low_strobe_en && iq_load && ext_fall &&
                       !low_byte_tag_pin;

    // User reads of the debug window, and clock choice
    assign user_hit = cpu_rd && !active_q &&
                      (cpu_addr >= ADDR_BASE) && (cpu_addr <= ADDR_LAST);
    assign alt_sel = pll_select_input && !clksel_q;

    // Read views; bit 0 of status is unimplemented
    assign status_view = {enable_q, active_q, tag_q, sdv_q, trace_q, clksel_q, unsecure_flag_q,
                          1'b0};
    assign position_view = {1'b0, block_base_bits, 3'b000};

    // Read data selection by address
    assign rdata_d = (addr == ADDR_STATUS) ? status_view :
                     (addr == ADDR_CCR) ? ccr_q :
                     (addr == ADDR_INR) ? position_view : 8'h00;

    // Enable bit, set by host or firmware writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else if (wr_enable) begin
            enable_q <= wdata[BIT_ENABLE];
        end
    end

    // Active flag: set on entry, cleared by the timed firmware store
    always_ff @(posedge mclk) begin
        if (rst) begin
            active_q <= reset_active;
        end else if (enter) begin
            active_q <= 1'b1;
        end else if (fw_exit) begin
            active_q <= 1'b0;
        end
    end

    // Tag bit; entry drops tagging and brings the serial system back
    always_ff @(posedge mclk) begin
        if (rst) begin
            tag_q <= 1'b0;
        end else if (enter) begin
            tag_q <= 1'b0;
        end else if (tag_start) begin
            tag_q <= 1'b1;
        end
    end

    // Start-up count between tag-go and the start of tagging
    always_ff @(posedge mclk) begin
        if (rst) begin
            tag_cnt_q <= 8'h00;
        end else if (enter) begin
            tag_cnt_q <= 8'h00;
        end else if (tag_start) begin
            tag_cnt_q <= TAG_CNT_W;
        end else if (tag_counting) begin
            tag_cnt_q <= tag_cnt_q - 8'h01;
        end
    end

    // Tagging turns the serial system off; no command is taken meanwhile
    always_ff @(posedge mclk) begin
        if (rst) begin
            tagging_q <= 1'b0;
            serial_q <= 1'b1;
        end else if (enter) begin
            tagging_q <= 1'b0;
            serial_q <= 1'b1;
        end else if (!tag_start && tag_done) begin
            tagging_q <= 1'b1;
            serial_q <= 1'b0;
        end
    end

    // Shift-data-valid: set wins over clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            sdv_q <= 1'b0;
        end else if (fw_data_done) begin
            sdv_q <= 1'b1;
        end else if (cmd_received || fw_exit) begin
            sdv_q <= 1'b0;
        end
    end

    // Trace follows back-to-back single-step commands
    always_ff @(posedge mclk) begin
        if (rst) begin
            trace_q <= 1'b0;
        end else if (cmd_received) begin
            trace_q <= single_step_command;
        end
    end

    // Clock select bit, hardware commands only
    always_ff @(posedge mclk) begin
        if (rst) begin
            clksel_q <= 1'b0;
        end else if (wr_clksel) begin
            clksel_q <= wdata[BIT_CLKSEL];
        end
    end

    // Switch delay: a rewrite of the same value must not stall the count
    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_cnt_q <= 8'h00;
        end else if (clk_change) begin
            clk_cnt_q <= CLK_CNT_W;
        end else if (clk_counting) begin
            clk_cnt_q <= clk_cnt_q - 8'h01;
        end
    end

    // Unsecure bit: secure firmware in special single-chip only
    always_ff @(posedge mclk) begin
        if (rst) begin
            unsecure_flag_q <= 1'b0;
        end else if (wr_unsecure_flag) begin
            unsecure_flag_q <= wdata[BIT_UNSECURE_FLAG];
        end
    end

    // Saved condition codes; entry capture wins over a write
    always_ff @(posedge mclk) begin
        if (rst) begin
            ccr_q <= special_single ? CCR_SPECIAL_RESET : CCR_RESET;
        end else if (enter) begin
            ccr_q <= condition_code_register;
        end else if (wr_ccr) begin
            ccr_q <= wdata;
        end
    end

    // Read port; the position register never takes a write
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rdata_valid_q <= rd_hit;
        end
    end

    // External clock history and low-byte tag pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_clk_q <= 1'b0;
            low_tag_q <= 1'b0;
        end else begin
            ext_clk_q <= external_bus_clock;
            low_tag_q <= low_tag_d;
        end
    end

    // Map visibility, clock choice and switch busy
    always_ff @(posedge mclk) begin
        if (rst) begin
            user_block_q <= 1'b0;
            alt_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            user_block_q <= user_hit;
            alt_q <= alt_sel;
            busy_q <= clk_counting;
        end
    end

    // Outputs straight from their flip-flops
    assign rdata = rdata_q;
    assign rdata_valid = rdata_valid_q;
    assign user_read_blocked = user_block_q;
    assign debug_active_flag = active_q;
    assign fw_table_mapped = active_q;
    assign serial_enabled = serial_q;
    assign tagging_active = tagging_q;
    assign low_tag = low_tag_q;
    assign use_alt_clock = alt_q;
    assign clock_switch_busy = busy_q;
    assign security_off = unsecure_flag_q;
    assign ccr_restore = ccr_q;
endmodule

/* tb/background_debug_status_regs_monitor.sv */
// Port-level checker for the debug status register block
`timescale 1ns/100ps
module background_debug_status_regs_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic debug_map_read_cmd,
    input wire logic [15:0] addr,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic serial_enabled,
    input wire logic activate_req,
    input wire logic exit_store,
    input wire logic std_fw,
    input wire logic debug_active_flag,
    input wire logic [7:0] condition_code_register,
    input wire logic [7:0] ccr_restore,
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic user_read_blocked,
    input wire logic tag_go_command,
    input wire logic tagging_active,
    input wire logic clock_switch_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic rd_hit;
    logic cpu_hit;
    // Accesses that land in the debug register window
    assign rd_hit = debug_map_read_cmd && serial_enabled && addr[15:3] == 13'h1fe0;
    assign cpu_hit = cpu_rd && cpu_addr[15:3] == 13'h1fe0 && !debug_active_flag;
    AST_RD_LAT: assert property (rd_hit |=> rdata_valid) else $error("read lost");
    AST_BIT0: assert property (rd_hit && addr == 16'hff01 |=> !rdata[0]) else $error("bit0");
    AST_ACT_SET: assert property ($rose(debug_active_flag) |-> $past(activate_req))
        else $error("active set without entry");
    AST_ACT_CLR: assert property ($fell(debug_active_flag) |-> $past(exit_store && std_fw))
        else $error("active cleared without exit");
    AST_CCR_CAP: assert property ($rose(debug_active_flag) |->
        ccr_restore == $past(condition_code_register)) else $error("codes not saved");
    AST_BLOCK: assert property (cpu_hit |=> user_read_blocked) else $error("user read");
    AST_TAG: assert property (tag_go_command && serial_enabled |->
        ##[17:18] (tagging_active && !serial_enabled)) else $error("tag start");
    AST_BUSY: assert property ($rose(clock_switch_busy) |->
        ##149 clock_switch_busy ##1 !clock_switch_busy) else $error("switch delay");
    // Main scenarios reached
    cover property ($rose(tagging_active));
    cover property ($rose(debug_active_flag));
    cover property ($rose(clock_switch_busy));
endmodule

/* tb/host_debug_model.sv */
// Host model that issues debug-map commands to the block
`timescale 1ns/100ps
module host_debug_model (
    input wire logic mclk,
    output logic debug_map_read_cmd,
    output logic debug_map_write_cmd,
    output logic exit_store,
    output logic hw_cmd,
    output logic std_fw,
    output logic secure_fw,
    output logic [15:0] addr,
    output logic [7:0] wdata
);
    // Idle lines at time zero
    initial begin
        {debug_map_read_cmd, debug_map_write_cmd, exit_store, hw_cmd, std_fw, secure_fw} = '0;
        {addr, wdata} = '0;
    end
    // One command over one taking edge; enable is set by hw_cmd, std_fw or secure_fw writes
    task automatic cmd(input logic [5:0] k, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        {debug_map_read_cmd, debug_map_write_cmd, exit_store, hw_cmd, std_fw, secure_fw} = k;
        {addr, wdata} = {a, d};
        @(posedge mclk);
        #1;
        {debug_map_read_cmd, debug_map_write_cmd, exit_store, hw_cmd, std_fw, secure_fw} = '0;
        {addr, wdata} = ~{a, d};
    endtask
endmodule

/* tb/tb_background_debug_status_regs.sv */
// Self-checking bench for the debug status register block
`timescale 1ns/100ps
module tb_background_debug_status_regs;
    import debug_regs_pkg::*;
    logic mclk, rst, debug_map_read_cmd, debug_map_write_cmd, hw_cmd, std_fw, secure_fw, cpu_rd;
    logic activate_req, exit_store, tag_go_command, fw_data_done, cmd_received, single_step_command;
    logic pll_select_input, external_bus_clock, low_byte_tag_pin, low_strobe_en, iq_load;
    logic rdata_valid, user_read_blocked, debug_active_flag, serial_enabled, tagging_active;
    logic use_alt_clock, security_off, low_tag, fw_table_mapped, clock_switch_busy;
    logic [15:0] addr, cpu_addr;
    logic [7:0] wdata, condition_code_register, rdata, ccr_restore;
    logic [3:0] block_base_bits;
    chip_mode_t chip_mode;
    int n_fail, checked;
    background_debug_status_regs background_debug_status_regs_inst (.mclk, .rst, .chip_mode,
        .debug_map_read_cmd, .debug_map_write_cmd, .hw_cmd, .secure_fw, .std_fw, .addr, .wdata,
        .cpu_rd, .cpu_addr, .activate_req, .exit_store, .tag_go_command, .fw_data_done,
        .cmd_received, .single_step_command, .condition_code_register, .block_base_bits,
        .pll_select_input, .external_bus_clock, .low_byte_tag_pin, .low_strobe_en, .iq_load,
        .rdata, .rdata_valid, .user_read_blocked, .debug_active_flag, .fw_table_mapped,
        .serial_enabled, .tagging_active, .low_tag, .use_alt_clock, .clock_switch_busy,
        .security_off, .ccr_restore);
    host_debug_model host_debug_model_inst (.mclk, .debug_map_read_cmd, .debug_map_write_cmd,
        .exit_store, .hw_cmd, .std_fw, .secure_fw, .addr, .wdata);
    // Byte compare with mismatch report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read one register and expect an answer
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        host_debug_model_inst.cmd(6'h20, a, 8'h00);
        chk(rdata, e);
        chk({7'h0, rdata_valid}, 8'h01);
    endtask
    // Single-cycle strobe on a bench input
    task automatic pulse(ref logic p);
        @(posedge mclk);
        #1 p = 1'b1;
        @(posedge mclk);
        #1 p = 1'b0;
    endtask
    task automatic stop_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #50us;
        n_fail++;
        stop_test();
    end
    // Main sequence in special single-chip mode
    initial begin
        {cpu_rd, activate_req, tag_go_command, fw_data_done, cmd_received} = '0;
        {single_step_command, pll_select_input, external_bus_clock} = '0;
        {low_byte_tag_pin, low_strobe_en, iq_load, n_fail, checked} = '0;
        chip_mode = MODE_SPECIAL_SINGLE;
        cpu_addr = 16'hff01;
        condition_code_register = 8'h3c;
        block_base_bits = 4'ha;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        rd_chk(ADDR_STATUS, 8'h40);
        rd_chk(ADDR_CCR, CCR_SPECIAL_RESET);
        host_debug_model_inst.cmd(6'h14, ADDR_STATUS, 8'h85);
        rd_chk(ADDR_STATUS, 8'hc4);
        host_debug_model_inst.cmd(6'h11, ADDR_STATUS, 8'h82);
        rd_chk(ADDR_STATUS, 8'hc6);
        chk({7'h0, security_off}, 8'h01);
        single_step_command = 1'b1;
        pulse(cmd_received);
        pulse(fw_data_done);
        rd_chk(ADDR_STATUS, 8'hde);
        host_debug_model_inst.cmd(6'h12, ADDR_CCR, 8'h5a);
        rd_chk(ADDR_CCR, 8'h5a);
        chk(ccr_restore, 8'h5a);
        host_debug_model_inst.cmd(6'h14, ADDR_INR, 8'hff);
        rd_chk(ADDR_INR, {1'b0, block_base_bits, 3'b000});
        host_debug_model_inst.cmd(6'h0a, 16'h0000, 8'h00);
        chk({6'h0, debug_active_flag, fw_table_mapped}, 8'h00);
        pulse(cpu_rd);
        chk({7'h0, user_read_blocked}, 8'h01);
        pulse(activate_req);
        chk({6'h0, debug_active_flag, fw_table_mapped}, 8'h03);
        rd_chk(ADDR_CCR, 8'h3c);
        host_debug_model_inst.cmd(6'h0a, 16'h0000, 8'h00);
        host_debug_model_inst.cmd(6'h14, ADDR_STATUS, 8'h04);
        pulse(activate_req);
        chk({7'h0, debug_active_flag}, 8'h00);
        pll_select_input = 1'b1;
        repeat (160) @(posedge mclk);
        host_debug_model_inst.cmd(6'h14, ADDR_STATUS, 8'h00);
        #40;
        chk({7'h0, use_alt_clock}, 8'h01);
        chk({7'h0, clock_switch_busy}, 8'h01);
        pulse(tag_go_command);
        repeat (20) @(posedge mclk);
        #1;
        chk({6'h0, tagging_active, serial_enabled}, 8'h02);
        {low_strobe_en, iq_load} = 2'b11;
        pulse(external_bus_clock);
        @(posedge mclk);
        #1;
        chk({7'h0, low_tag}, 8'h01);
        host_debug_model_inst.cmd(6'h20, ADDR_CCR, 8'h00);
        chk({7'h0, rdata_valid}, 8'h00);
        stop_test();
    end
endmodule
bind background_debug_status_regs background_debug_status_regs_monitor mon_inst (.mclk, .rst,
    .debug_map_read_cmd, .addr, .rdata, .rdata_valid, .serial_enabled, .activate_req,
    .exit_store, .std_fw, .debug_active_flag, .condition_code_register, .ccr_restore, .cpu_rd,
    .cpu_addr, .user_read_blocked, .tag_go_command, .tagging_active, .clock_switch_busy);
